// ===== logic/acc_pkg.sv
// constants and types of the converter conversion control block
// Behaviour
// (RQ1) control write aborts and restarts unless channel off; code restarts only with software trigger selected
// (RQ2) compare off: done flag set per conversion
// (RQ3) compare on: done flag only when compare true
// (RQ4) control write or low result read clears flag
// (RQ5) flag set with enable raises done interrupt
// (RQ6) single mode: one conversion per trigger
// (RQ7) continuous mode: back-to-back after trigger
// (RQ8) five-bit channel field selects converter input
// (RQ9) all-ones channel powers down, no extra conversion
// (RQ10) single mode idles powered down after completion
// (RQ11) active bit set on start, cleared on end/abort
// (RQ12) trigger select: software write or hardware input
// (RQ13) compare enable bit turns compare on
// (RQ14) polarity: less-than, or greater-or-equal
// (RQ15) software writes zero to reserved bits 1:0
// (RQ16) results stored at completion unless compare fails; code skips it while locked and stores result minus compare if compare on
// (RQ17) resolution code selects 8, 12, 10 bits
// (RQ18) hardware trigger is periodic counter overflow
// (RQ19) trigger input synchronised and edge detected
`default_nettype none
package acc_pkg;
  // ****************************************************
  // register offsets
  // ****************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TRIG = 8'h04;
  localparam logic [7:0] OFF_RES_LO = 8'h08;
  localparam logic [7:0] OFF_RES_HI = 8'h0C;
  localparam logic [7:0] OFF_CMP_LO = 8'h10;
  localparam logic [7:0] OFF_CMP_HI = 8'h14;
  localparam logic [7:0] OFF_CFG = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
  // ****************************************************
  // field positions
  // ****************************************************
  localparam int BIT_DONE = 7;
  localparam int BIT_IEN = 6;
  localparam int BIT_CONT = 5;
  localparam int BIT_ACTIVE = 7;
  localparam int BIT_TSEL = 6;
  localparam int BIT_CMPEN = 5;
  localparam int BIT_CMPGE = 4;
  localparam int BIT_MODE = 2;
  localparam int EV_DONE = 0;
  localparam int EV_ABORT = 1;
  // ****************************************************
  // codes and reset values
  // ****************************************************
  localparam logic [4:0] CHAN_OFF = 5'h1F;
  localparam logic [4:0] CHAN_RST = 5'h1F;
  localparam logic [1:0] MODE_8 = 2'h0;
  localparam logic [1:0] MODE_12 = 2'h1;
  localparam logic [1:0] MODE_10 = 2'h2;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [11:0] MASK_8 = 12'h0FF;
  localparam logic [11:0] MASK_10 = 12'h3FF;
  localparam logic [11:0] MASK_12 = 12'hFFF;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b01,
    ACC_CONV = 2'b10
  } acc_state_t;
  typedef struct packed {
    logic start;
    logic abort;
    logic power;
    logic [4:0] channel;
    logic [1:0] mode;
  } acc_core_req_t;
  typedef struct packed {
    logic done;
    logic [11:0] result;
  } acc_core_rsp_t;
  typedef struct packed {
    acc_state_t st;
    logic flag;
    logic ien;
    logic cont;
    logic [4:0] chan;
    logic tsel;
    logic cmp_en;
    logic cmp_ge;
    logic [11:0] result;
    logic [11:0] cmpval;
    logic [1:0] mode;
    logic lock;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [2:0] sync;
    acc_core_req_t core;
    logic done_irq;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } acc_regs_t;
endpackage
`default_nettype wire

// ===== logic/acc_ctrl.sv
// conversion control, status, compare and apb register file
`timescale 1ns/100ps
`default_nettype none
module acc_ctrl
  import acc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_trigger_in,
  input wire acc_core_rsp_t core_rsp,
  output acc_core_req_t core_req,
  output logic done_irq,
  output logic irq
);
  acc_regs_t s;
  acc_regs_t n;
  logic acc;
  logic wr;
  logic rd;
  logic setup;
  logic hit;
  logic [31:0] rdval;
  logic trig_ev;
  logic [11:0] msk;
  logic [11:0] res;
  logic [11:0] cv;
  logic cmp_true;
  logic done_ok;
  logic done_ev;
  logic abort_ev;
  logic flag_clr;
  logic [1:0] ev;

  // ****************************************************
  // read mux
  // ****************************************************
  always_comb begin
    hit = 1'b1;
    rdval = 32'h0;
    if (paddr == OFF_CTRL) begin
      rdval[7:0] = {s.flag, s.ien, s.cont, s.chan};
    end else if (paddr == OFF_TRIG) begin
      rdval[7:0] = {s.st == ACC_CONV, s.tsel, s.cmp_en, s.cmp_ge, 4'h0}; // [RQ11]
    end else if (paddr == OFF_RES_LO) begin
      rdval[7:0] = s.result[7:0];
    end else if (paddr == OFF_RES_HI) begin
      rdval[3:0] = s.result[11:8];
    end else if (paddr == OFF_CMP_LO) begin
      rdval[7:0] = s.cmpval[7:0];
    end else if (paddr == OFF_CMP_HI) begin
      rdval[3:0] = s.cmpval[11:8];
    end else if (paddr == OFF_CFG) begin
      rdval[3:2] = s.mode;
    end else if (paddr == OFF_IRQ_STAT) begin
      rdval[1:0] = s.irq_stat;
    end else if (paddr == OFF_IRQ_MASK) begin
      rdval[1:0] = s.irq_mask;
    end else begin
      hit = 1'b0;
    end
  end

  // ****************************************************
  // compare and result shaping
  // ****************************************************
  always_comb begin
    if (s.mode == MODE_8) begin
      msk = MASK_8; // [RQ17]
    end else if (s.mode == MODE_10) begin
      msk = MASK_10; // [RQ17]
    end else begin
      msk = MASK_12; // [RQ17]
    end
    res = core_rsp.result & msk;
    cv = s.cmpval & msk;
    cmp_true = s.cmp_ge ? (res >= cv) : (res < cv); // [RQ14]
    done_ok = !s.cmp_en || cmp_true; // [RQ2] [RQ3] [RQ13]
  end

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    n = s;
    n.core.start = 1'b0;
    n.core.abort = 1'b0;
    setup = psel && !penable;
    acc = psel && penable && s.pready;
    wr = acc && pwrite && hit;
    rd = acc && !pwrite && hit;
    done_ev = 1'b0;
    abort_ev = 1'b0;
    flag_clr = 1'b0;
    // trigger sync, edge from second and third stages
    n.sync = {s.sync[1:0], hw_trigger_in}; // [RQ19]
    trig_ev = s.sync[1] && !s.sync[2]; // [RQ19] [RQ18]
    // apb answer from flops, one access cycle
    n.pready = setup;
    n.pslverr = setup && !hit;
    n.prdata = setup ? rdval : 32'h0;
    // completion
    if (s.st == ACC_CONV && core_rsp.done) begin
      if (done_ok) begin
        done_ev = 1'b1; // [RQ2] [RQ3]
        if (!s.lock) begin
          n.result = s.cmp_en ? ((res - cv) & msk) : res; // [RQ16]
        end
      end
      if (s.cont && s.chan != CHAN_OFF) begin
        n.core.start = 1'b1; // [RQ7]
      end else begin
        n.st = ACC_IDLE; // [RQ6] [RQ10] [RQ11]
      end
    end else if (s.st == ACC_IDLE && s.tsel && trig_ev && s.chan != CHAN_OFF) begin
      n.st = ACC_CONV; // [RQ12] [RQ6] [RQ7]
      n.core.start = 1'b1;
    end
    // register writes
    if (wr) begin
      if (paddr == OFF_CTRL) begin
        n.ien = pwdata[BIT_IEN];
        n.cont = pwdata[BIT_CONT];
        n.chan = pwdata[4:0]; // [RQ8]
        flag_clr = 1'b1; // [RQ4]
        n.core.start = 1'b0;
        if (s.st == ACC_CONV && !(core_rsp.done && n.st == ACC_IDLE)) begin
          n.core.abort = 1'b1; // [RQ1]
          abort_ev = 1'b1;
        end
        if (pwdata[4:0] != CHAN_OFF && !s.tsel) begin
          n.st = ACC_CONV; // [RQ1] [RQ12]
          n.core.start = 1'b1;
        end else begin
          n.st = ACC_IDLE; // [RQ9] [RQ11]
        end
      end else if (paddr == OFF_TRIG) begin
        n.tsel = pwdata[BIT_TSEL]; // [RQ12]
        n.cmp_en = pwdata[BIT_CMPEN]; // [RQ13]
        n.cmp_ge = pwdata[BIT_CMPGE]; // [RQ14]
      end else if (paddr == OFF_CMP_LO) begin
        n.cmpval[7:0] = pwdata[7:0];
      end else if (paddr == OFF_CMP_HI) begin
        n.cmpval[11:8] = pwdata[3:0];
      end else if (paddr == OFF_CFG) begin
        n.mode = pwdata[BIT_MODE +: 2]; // [RQ17]
      end else if (paddr == OFF_IRQ_MASK) begin
        n.irq_mask = pwdata[1:0];
      end
    end
    // reads with side effects
    if (rd && paddr == OFF_RES_LO) begin
      flag_clr = 1'b1; // [RQ4]
      n.lock = 1'b0;
    end
    if (rd && paddr == OFF_RES_HI && s.mode != MODE_8) begin
      n.lock = 1'b1;
    end
    // flag: set beats clear
    n.flag = (s.flag && !flag_clr) || done_ev; // [RQ2] [RQ3] [RQ4]
    ev = 2'b00;
    ev[EV_DONE] = done_ev;
    ev[EV_ABORT] = abort_ev;
    if (rd && paddr == OFF_IRQ_STAT) begin
      n.irq_stat = ev;
    end else begin
      n.irq_stat = s.irq_stat | ev;
    end
    // core drive
    n.core.channel = n.chan;
    n.core.mode = n.mode;
    n.core.power = n.st == ACC_CONV; // [RQ9] [RQ10]
    n.done_irq = n.flag && n.ien; // [RQ5]
    n.irq = |(n.irq_stat & n.irq_mask);
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= ACC_IDLE;
      s.chan <= CHAN_RST;
      s.mode <= MODE_RST;
      s.irq_mask <= IRQ_MASK_RST;
      s.core.channel <= CHAN_RST;
      s.core.mode <= MODE_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign core_req = s.core;
  assign done_irq = s.done_irq;
  assign irq = s.irq;
endmodule
`default_nettype wire

// ===== tb/acc_ctrl_properties.sv
// port assertions of the conversion control block
`timescale 1ns/100ps
`default_nettype none
module acc_ctrl_properties
  import acc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic hw_trigger_in,
  input wire acc_core_rsp_t core_rsp,
  input wire acc_core_req_t core_req,
  input wire logic done_irq
);
  // ********
  // checks
  // ********
  logic wr;
  assign wr = psel && penable && pready && pwrite && paddr == OFF_CTRL;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_write_aborts: assert property (
    wr && core_req.power && !core_rsp.done |=> core_req.abort) else $error("no abort");
  a_abort_cause: assert property (core_req.abort |-> $past(wr)) else $error("stray abort");
  a_off_idle: assert property (
    wr && pwdata[4:0] == CHAN_OFF |=> !core_req.start && !core_req.power) else $error("off runs");
  a_start_cause: assert property (
    core_req.start |-> $past(wr) || $past(core_rsp.done) || $past(hw_trigger_in, 2))
    else $error("stray start");
  a_start_pulse: assert property (core_req.start |=> !core_req.start) else $error("long start");
  a_start_power: assert property (core_req.start |-> core_req.power) else $error("no power");
  a_start_chan: assert property (
    core_req.start |-> core_req.channel != CHAN_OFF) else $error("start while off");
  a_write_clears: assert property (
    wr && !core_rsp.done |=> !done_irq) else $error("flag kept");
endmodule
bind acc_ctrl acc_ctrl_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .hw_trigger_in(hw_trigger_in), .core_rsp(core_rsp), .core_req(core_req), .done_irq(done_irq));
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench of the conversion control block
`timescale 1ns/100ps
`default_nettype none
module testbench
  import acc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, hw_trigger_in, pready, pslverr, done_irq, irq;
  logic err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  acc_core_rsp_t core_rsp;
  acc_core_req_t core_req;
  int failures, samples_checked, starts;
  acc_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_trigger_in(hw_trigger_in), .core_rsp(core_rsp),
    .core_req(core_req), .done_irq(done_irq), .irq(irq));
  // ********
  // tasks
  // ********
  initial forever #2 pclk = ~pclk;
  always @(posedge pclk) if (core_req.start === 1'b1) starts++;
  task automatic chk(input string s, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk($sformatf("reg %h", a), e, rd);
  endtask
  task automatic conv(input logic [11:0] r);
    repeat (2) @(posedge pclk);
    core_rsp <= {1'b1, r};
    @(posedge pclk) core_rsp.done <= 0;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task automatic cmp(input logic [31:0] t, f, s, input logic [11:0] r);
    apb(1, OFF_TRIG, t);
    apb(1, OFF_CTRL, 3);
    conv(r);
    rdc(OFF_CTRL, f);
    rdc(OFF_RES_LO, s);
  endtask
  task finish_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    finish_test;
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, hw_trigger_in, paddr, pwdata, core_rsp} = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rdc(OFF_CTRL, 32'h1F);
    apb(1, OFF_IRQ_MASK, 1);
    apb(1, OFF_CTRL, 32'h43);
    rdc(OFF_TRIG, 32'h80);
    conv(12'h0AB);
    rdc(OFF_CTRL, 32'hC3);
    chk("irqs", 3, {done_irq, irq});
    chk("power", 0, core_req.power);
    rdc(OFF_IRQ_STAT, 1);
    chk("irq", 0, irq);
    rdc(OFF_RES_LO, 32'hAB);
    rdc(OFF_CTRL, 32'h43);
    apb(1, OFF_CTRL, 3);
    apb(1, OFF_CTRL, 5);
    apb(1, OFF_CTRL, 32'h1F);
    chk("starts", 3, starts);
    apb(1, OFF_CMP_LO, 32'h10);
    cmp(32'h20, 32'h03, 32'hAB, 12'h020);
    cmp(32'h20, 32'h83, 32'hF8, 12'h008);
    cmp(32'h30, 32'h83, 32'h10, 12'h020);
    apb(1, OFF_TRIG, 0);
    apb(1, OFF_CTRL, 32'h23);
    conv(12'h005);
    chk("starts", 8, starts);
    apb(1, OFF_CTRL, 32'h3F);
    chk("power", 0, core_req.power);
    apb(1, OFF_TRIG, 32'h40);
    apb(1, OFF_CTRL, 3);
    @(posedge pclk) hw_trigger_in <= 1;
    repeat (10) @(posedge pclk);
    hw_trigger_in <= 0;
    conv(12'h001);
    chk("starts", 9, starts);
    rdc(8'hFC, 0);
    chk("pslverr", 1, err);
    finish_test;
  end
endmodule
`default_nettype wire
